// file: logic/mia_pkg.sv
// shared constants, register map and types for the memory/16-bit arithmetic datapath
package mia_pkg;

	// register byte offsets on the bus
	localparam int          AW          = 8;
	localparam logic [AW-1:0] OFF_CTRL   = 8'h00;
	localparam logic [AW-1:0] OFF_STATUS = 8'h04;
	localparam logic [AW-1:0] OFF_INSTR  = 8'h08;
	localparam logic [AW-1:0] OFF_ACCF   = 8'h0c;
	localparam logic [AW-1:0] OFF_BC     = 8'h10;
	localparam logic [AW-1:0] OFF_DE     = 8'h14;
	localparam logic [AW-1:0] OFF_PTR_PAIR     = 8'h18;
	localparam logic [AW-1:0] OFF_STACK_PTR    = 8'h1c;
	localparam logic [AW-1:0] OFF_INDEX_FIRST  = 8'h20;
	localparam logic [AW-1:0] OFF_INDEX_SECOND = 8'h24;
	localparam logic [AW-1:0] OFF_MEMD   = 8'h28;
	localparam logic [AW-1:0] OFF_MEMA   = 8'h2c;
	localparam logic [2:0]  SIZE_WORD   = 3'h2;

	// field positions
	localparam int CTRL_START_BIT = 0;
	localparam int STAT_BUSY_BIT  = 0;
	localparam int STAT_DONE_BIT  = 1;
	localparam int STAT_ILL_BIT   = 2;
	localparam int FLAG_S  = 7;
	localparam int FLAG_Z  = 6;
	localparam int FLAG_H  = 4;
	localparam int FLAG_PV = 2;
	localparam int FLAG_N  = 1;
	localparam int FLAG_C  = 0;
	localparam int PFX_SEL_BIT = 5;

	// reset values
	localparam logic [7:0]  RST_BYTE  = 8'h00;
	localparam logic [15:0] RST_WORD  = 16'h0000;
	localparam logic [23:0] RST_INSTR = 24'h000000;

	// opcodes and patterns
	localparam logic [7:0] OPC_CMP_MEM = 8'hbe;
	localparam logic [7:0] OPC_INC_MEM = 8'h34;
	localparam logic [7:0] OPC_DEC_MEM = 8'h35;
	localparam logic [7:0] PFX_MASK    = 8'hdf;
	localparam logic [7:0] PFX_VAL     = 8'hdd;
	localparam logic [7:0] EXT_PFX     = 8'hed;
	localparam logic [7:0] PAIR_MASK   = 8'hcf;
	localparam logic [7:0] PAT_ADD16   = 8'h09;
	localparam logic [7:0] PAT_ADC16   = 8'h4a;
	localparam logic [7:0] PAT_SUBB16  = 8'h42;
	localparam logic [7:0] PAT_INC16   = 8'h03;
	localparam logic [7:0] PAT_DEC16   = 8'h0b;
	localparam logic [7:0] VAL_DEC_OVF = 8'h80;
	localparam logic [7:0] VAL_INC_OVF = 8'h7f;

	// execution lengths in T states, one T state per clock
	localparam int          TW             = 5;
	localparam logic [TW-1:0] T_CMP_MEM    = 5'h07;
	localparam logic [TW-1:0] T_CMP_IDX    = 5'h13;
	localparam logic [TW-1:0] T_INCDEC_MEM = 5'h0b;
	localparam logic [TW-1:0] T_INCDEC_IDX = 5'h17;
	localparam logic [TW-1:0] T_ADD16      = 5'h0b;
	localparam logic [TW-1:0] T_ADD16_IDX  = 5'h0f;
	localparam logic [TW-1:0] T_EXT16      = 5'h0f;
	localparam logic [TW-1:0] T_INCDEC16   = 5'h06;
	localparam logic [TW-1:0] T_INCDEC16_X = 5'h0a;

	typedef enum logic [3:0] {
		OP_NONE, OP_CMP, OP_INC8, OP_DEC8, OP_ADD16, OP_ADC16, OP_SUBB16, OP_INC16, OP_DEC16
	} mia_op_t;

endpackage // mia_pkg

// file: logic/mia_alu_if.sv
// operand and result bundle between the control core and the arithmetic unit
interface mia_alu_if;
	mia_pkg::mia_op_t op;
	logic [7:0]       acc;
	logic [7:0]       mem_in;
	logic [15:0]      dst;
	logic [15:0]      src;
	logic [7:0]       flags_in;
	logic [7:0]       res8;
	logic [15:0]      res16;
	logic [7:0]       flags_out;

	modport ctl (output op, acc, mem_in, dst, src, flags_in, input res8, res16, flags_out);
	modport alu (input op, acc, mem_in, dst, src, flags_in, output res8, res16, flags_out);
endinterface // mia_alu_if

// file: logic/mia_alu.sv
// combinational 8/16-bit arithmetic with flag generation
module mia_alu (
	// operands in, results out
	mia_alu_if.alu bus
);
	import mia_pkg::*;

	logic [8:0]  w9;
	logic [4:0]  w5;
	logic [16:0] w17;
	logic [12:0] w13;
	logic [7:0]  f;

	always_comb begin
		f  = bus.flags_in;
		w9 = '0;
		w5 = '0;
		w17 = '0;
		w13 = '0;
		bus.res8  = bus.mem_in;
		bus.res16 = bus.dst;
		unique case (bus.op)
			OP_NONE: begin
			end
			// RL1 compare flags
			OP_CMP: begin
				w9 = {1'b0, bus.acc} - {1'b0, bus.mem_in};
				w5 = {1'b0, bus.acc[3:0]} - {1'b0, bus.mem_in[3:0]};
				f[FLAG_PV] = (bus.acc[7] != bus.mem_in[7]) && (w9[7] != bus.acc[7]);
				f[FLAG_N]  = 1'b1;
				f[FLAG_C]  = w9[8];
			end
			// RL5 RL6 decrement flags
			OP_DEC8: begin
				w9 = {1'b0, bus.mem_in - 8'h01};
				w5 = {1'b0, bus.mem_in[3:0]} - 5'h01;
				bus.res8   = w9[7:0];
				f[FLAG_PV] = (bus.mem_in == VAL_DEC_OVF);
				f[FLAG_N]  = 1'b1;
			end
			// RL8 RL9 increment flags
			OP_INC8: begin
				w9 = {1'b0, bus.mem_in + 8'h01};
				w5 = {1'b0, bus.mem_in[3:0]} + 5'h01;
				bus.res8   = w9[7:0];
				f[FLAG_PV] = (bus.mem_in == VAL_INC_OVF);
				f[FLAG_N]  = 1'b0;
			end
			// RL12 plain add keeps s z pv
			OP_ADD16: begin
				w17 = {1'b0, bus.dst} + {1'b0, bus.src};
				w13 = {1'b0, bus.dst[11:0]} + {1'b0, bus.src[11:0]};
				bus.res16 = w17[15:0];
				f[FLAG_H] = w13[12];
				f[FLAG_N] = 1'b0;
				f[FLAG_C] = w17[16];
			end
			// RL15 add with carry
			OP_ADC16: begin
				w17 = {1'b0, bus.dst} + {1'b0, bus.src} + {16'h0000, bus.flags_in[FLAG_C]};
				w13 = {1'b0, bus.dst[11:0]} + {1'b0, bus.src[11:0]} + {12'h000, bus.flags_in[FLAG_C]};
				bus.res16  = w17[15:0];
				f[FLAG_PV] = (bus.dst[15] == bus.src[15]) && (w17[15] != bus.dst[15]);
				f[FLAG_N]  = 1'b0;
			end
			// RL17 subtract with borrow
			OP_SUBB16: begin
				w17 = {1'b0, bus.dst} - {1'b0, bus.src} - {16'h0000, bus.flags_in[FLAG_C]};
				w13 = {1'b0, bus.dst[11:0]} - {1'b0, bus.src[11:0]} - {12'h000, bus.flags_in[FLAG_C]};
				bus.res16  = w17[15:0];
				f[FLAG_PV] = (bus.dst[15] != bus.src[15]) && (w17[15] != bus.dst[15]);
				f[FLAG_N]  = 1'b1;
			end
			// RL19 RL20 pair step, no flags
			OP_INC16: bus.res16 = bus.dst + 16'h0001;
			OP_DEC16: bus.res16 = bus.dst - 16'h0001;
		endcase
		if (bus.op == OP_CMP || bus.op == OP_INC8 || bus.op == OP_DEC8) begin
			f[FLAG_S] = w9[7];
			f[FLAG_Z] = (w9[7:0] == 8'h00);
			f[FLAG_H] = w5[4];
		end
		if (bus.op == OP_ADC16 || bus.op == OP_SUBB16) begin
			f[FLAG_S] = w17[15];
			f[FLAG_Z] = (w17[15:0] == 16'h0000);
			f[FLAG_H] = w13[12];
			f[FLAG_C] = w17[16];
		end
		bus.flags_out = f;
	end

endmodule // mia_alu

// file: logic/mia_top.sv
// memory compare/inc/dec and 16-bit arithmetic datapath behind an AHB-Lite register slave
// What this block does
// RL1: compare subtracts memory from accumulator, discards result, sets s z h pv n c
// RL2: compare through pointer pair decodes from be and takes 7 T states
// RL3: indexed compare is prefix, opcode, displacement and takes 19 T states
// RL4: prefix 11x11101, bit 5 picks first or second index register
// RL5: memory decrement writes operand minus one, n set, carry kept
// RL6: decrement sets parity_overflow only when operand was 80
// RL7: memory decrement through pointer pair decodes from 35, 11 T states
// RL8: memory increment writes operand plus one, n cleared, carry kept
// RL9: increment sets parity_overflow only when operand was 7f
// RL10: memory increment through pointer pair decodes from 34, 11 T states
// RL11: indexed increment and decrement are prefix, opcode, displacement, 23 T states
// RL12: plain 16-bit add keeps s z pv, h from bit 11, c from 15
// RL13: add pair into pointer pair decodes from 00pp1001, 11 T states
// RL14: prefixed 00pp1001 adds into chosen index register, 15 T states
// RL15: 16-bit add with carry sets s z h pv c, clears n
// RL16: add with carry is ed then 01pp1010, 15 T states
// RL17: 16-bit subtract with borrow sets s z h pv c, sets n
// RL18: subtract with borrow is ed then 01pp0010, 15 T states
// RL19: pair increment adds one, no flags, 6 T states unprefixed
// RL20: pair decrement subtracts one, no flags
// RL21: pair field 00 first, 01 second, 10 pointer or index, 11 stack pointer
// RL22: displacement is signed and added to the index register
module mia_top (
	// clock and reset
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	// ahb-lite slave
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic      [31:0]          hrdata,
	output logic                      hreadyout,
	output logic                      hresp
);
	import mia_pkg::*;

	typedef enum logic {ST_IDLE, ST_EXEC} mia_state_t;

	// bus slave state
	logic                 dph_valid;
	logic                 dph_write;
	logic [AW-1:0]        dph_addr;
	logic                 rd_wait;
	logic                 next_dph_valid;
	logic                 next_dph_write;
	logic [AW-1:0]        next_dph_addr;
	logic                 next_rd_wait;
	logic [31:0]          next_hrdata;
	logic                 next_hreadyout;
	logic [31:0]          rd_mux;
	logic                 accept;
	logic                 wr_en;

	// architectural and control state
	mia_state_t           state;
	mia_state_t           next_state;
	logic [7:0]           acc;
	logic [7:0]           flags;
	logic [15:0]          bc;
	logic [15:0]          de;
	logic [15:0]          pointer_pair;
	logic [15:0]          stack_pointer;
	logic [15:0]          index_reg_first;
	logic [15:0]          index_reg_second;
	logic [7:0]           mem_data;
	logic [15:0]          mem_addr;
	logic [23:0]          instr;
	logic                 done;
	logic                 illegal;
	logic [TW-1:0]        tcnt;
	logic [TW-1:0]        last_t;
	logic [7:0]           next_acc;
	logic [7:0]           next_flags;
	logic [15:0]          next_bc;
	logic [15:0]          next_de;
	logic [15:0]          next_pointer_pair;
	logic [15:0]          next_stack_pointer;
	logic [15:0]          next_index_reg_first;
	logic [15:0]          next_index_reg_second;
	logic [7:0]           next_mem_data;
	logic [15:0]          next_mem_addr;
	logic [23:0]          next_instr;
	logic                 next_done;
	logic                 next_illegal;
	logic [TW-1:0]        next_tcnt;
	logic [TW-1:0]        next_last_t;

	// decode results
	logic [7:0]           op_byte;
	logic                 is_pfx;
	logic                 is_ext;
	logic                 idx_sel;
	logic [1:0]           pfield;
	logic [15:0]          index_val;
	logic [15:0]          pair_val;
	logic [15:0]          eff_addr;
	mia_op_t              dec_op;
	logic [TW-1:0]        dec_t;
	logic [1:0]           wr_slot;
	logic                 start;

	mia_alu_if alu_bus ();

	mia_alu u_alu (
		.bus (alu_bus.alu)
	);

	assign wr_en  = dph_valid && dph_write;
	assign accept = hsel && htrans[1] && hready && (hsize == SIZE_WORD);
	assign start  = wr_en && (dph_addr == OFF_CTRL) && hwdata[CTRL_START_BIT] && (state == ST_IDLE);

	// register read mux; unmapped offsets read as zero
	always_comb begin
		rd_mux = 32'h00000000;
		unique case (dph_addr)
			OFF_STATUS: rd_mux = {16'h0000, 3'h0, last_t, 5'h00, illegal, done, state == ST_EXEC};
			OFF_INSTR:  rd_mux = {8'h00, instr};
			OFF_ACCF:   rd_mux = {16'h0000, acc, flags};
			OFF_BC:     rd_mux = {16'h0000, bc};
			OFF_DE:     rd_mux = {16'h0000, de};
			OFF_PTR_PAIR:     rd_mux = {16'h0000, pointer_pair};
			OFF_STACK_PTR:    rd_mux = {16'h0000, stack_pointer};
			OFF_INDEX_FIRST:  rd_mux = {16'h0000, index_reg_first};
			OFF_INDEX_SECOND: rd_mux = {16'h0000, index_reg_second};
			OFF_MEMD:   rd_mux = {24'h000000, mem_data};
			OFF_MEMA:   rd_mux = {16'h0000, mem_addr};
			default:    rd_mux = 32'h00000000;
		endcase
	end

	// reads take one wait state so a write committed just before is seen
	always_comb begin
		next_dph_valid = dph_valid;
		next_dph_write = dph_write;
		next_dph_addr  = dph_addr;
		next_rd_wait   = 1'b0;
		next_hrdata    = hrdata;
		next_hreadyout = 1'b1;
		if (rd_wait) begin
			next_hrdata    = rd_mux;
			next_dph_valid = 1'b0;
		end else if (hready) begin
			next_dph_valid = accept;
			next_dph_write = hwrite;
			next_dph_addr  = haddr[AW-1:0];
			if (accept && !hwrite) begin
				next_rd_wait   = 1'b1;
				next_hreadyout = 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dph_valid <= 1'b0;
			dph_write <= 1'b0;
			dph_addr  <= '0;
			rd_wait   <= 1'b0;
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			dph_valid <= next_dph_valid;
			dph_write <= next_dph_write;
			dph_addr  <= next_dph_addr;
			rd_wait   <= next_rd_wait;
			hrdata    <= next_hrdata;
			hreadyout <= next_hreadyout;
			hresp     <= 1'b0;
		end
	end

	// instruction decode from the staged bytes
	always_comb begin
		// RL4 index prefix and select bit
		is_pfx  = (instr[7:0] & PFX_MASK) == PFX_VAL;
		idx_sel = instr[PFX_SEL_BIT];
		is_ext  = instr[7:0] == EXT_PFX;
		op_byte = (is_pfx || is_ext) ? instr[15:8] : instr[7:0];
		pfield  = op_byte[5:4];
		index_val = idx_sel ? index_reg_second : index_reg_first;
		// RL21 pair field mapping
		unique case (pfield)
			2'h0: pair_val = bc;
			2'h1: pair_val = de;
			2'h2: pair_val = is_pfx ? index_val : pointer_pair;
			2'h3: pair_val = stack_pointer;
		endcase
		// RL22 signed displacement
		eff_addr = is_pfx ? index_val + {{8{instr[23]}}, instr[23:16]} : pointer_pair;
		dec_op  = OP_NONE;
		dec_t   = '0;
		wr_slot = 2'h2;
		if (is_ext) begin
			// RL16 add with carry decode
			if ((op_byte & PAIR_MASK) == PAT_ADC16) begin
				dec_op = OP_ADC16;
				dec_t  = T_EXT16;
			// RL18 subtract with borrow decode
			end else if ((op_byte & PAIR_MASK) == PAT_SUBB16) begin
				dec_op = OP_SUBB16;
				dec_t  = T_EXT16;
			end
		// RL2 RL3 compare decode and length
		end else if (op_byte == OPC_CMP_MEM) begin
			dec_op = OP_CMP;
			dec_t  = is_pfx ? T_CMP_IDX : T_CMP_MEM;
		// RL7 RL10 RL11 memory step decode and length
		end else if (op_byte == OPC_INC_MEM || op_byte == OPC_DEC_MEM) begin
			dec_op = op_byte[0] ? OP_DEC8 : OP_INC8;
			dec_t  = is_pfx ? T_INCDEC_IDX : T_INCDEC_MEM;
		// RL13 RL14 16-bit add decode and length
		end else if ((op_byte & PAIR_MASK) == PAT_ADD16) begin
			dec_op = OP_ADD16;
			dec_t  = is_pfx ? T_ADD16_IDX : T_ADD16;
		// RL19 RL20 pair step decode and length
		end else if ((op_byte & PAIR_MASK) == PAT_INC16 || (op_byte & PAIR_MASK) == PAT_DEC16) begin
			dec_op  = op_byte[3] ? OP_DEC16 : OP_INC16;
			dec_t   = is_pfx ? T_INCDEC16_X : T_INCDEC16;
			wr_slot = pfield;
		end
		if (is_pfx && (instr[15:8] == EXT_PFX || (instr[15:8] & PFX_MASK) == PFX_VAL)) begin
			dec_op = OP_NONE;
		end
	end

	// operands; the arithmetic result is only committed on the last T state
	assign alu_bus.op       = (state == ST_EXEC) ? dec_op : OP_NONE;
	assign alu_bus.acc      = acc;
	assign alu_bus.mem_in   = mem_data;
	assign alu_bus.dst      = (wr_slot == 2'h2) ? (is_pfx ? index_val : pointer_pair) : pair_val;
	assign alu_bus.src      = pair_val;
	assign alu_bus.flags_in = flags;

	always_comb begin
		next_state    = state;
		next_acc      = acc;
		next_flags    = flags;
		next_bc       = bc;
		next_de       = de;
		next_pointer_pair     = pointer_pair;
		next_stack_pointer    = stack_pointer;
		next_index_reg_first  = index_reg_first;
		next_index_reg_second = index_reg_second;
		next_mem_data = mem_data;
		next_mem_addr = mem_addr;
		next_instr    = instr;
		next_done     = done;
		next_illegal  = illegal;
		next_tcnt     = tcnt;
		next_last_t   = last_t;
		unique case (state)
			ST_IDLE: begin
				// software may only load operands while nothing executes
				if (wr_en) begin
					unique case (dph_addr)
						OFF_INSTR: next_instr = hwdata[23:0];
						OFF_ACCF:  {next_acc, next_flags} = hwdata[15:0];
						OFF_BC:    next_bc = hwdata[15:0];
						OFF_DE:    next_de = hwdata[15:0];
						OFF_PTR_PAIR:     next_pointer_pair = hwdata[15:0];
						OFF_STACK_PTR:    next_stack_pointer = hwdata[15:0];
						OFF_INDEX_FIRST:  next_index_reg_first = hwdata[15:0];
						OFF_INDEX_SECOND: next_index_reg_second = hwdata[15:0];
						OFF_MEMD:  next_mem_data = hwdata[7:0];
						default: begin
						end
					endcase
				end
				if (start) begin
					next_done    = dec_op == OP_NONE;
					next_illegal = dec_op == OP_NONE;
					next_tcnt    = {{(TW-1){1'b0}}, 1'b1};
					if (dec_op != OP_NONE) begin
						next_state    = ST_EXEC;
						next_mem_addr = eff_addr;
					end
				end
			end
			ST_EXEC: begin
				next_tcnt = tcnt + {{(TW-1){1'b0}}, 1'b1};
				if (tcnt == dec_t) begin
					next_state  = ST_IDLE;
					next_done   = 1'b1;
					next_last_t = tcnt;
					// RL1 compare leaves the accumulator untouched
					next_flags  = alu_bus.flags_out;
					// RL5 RL8 write back to the same location
					if (dec_op == OP_INC8 || dec_op == OP_DEC8) begin
						next_mem_data = alu_bus.res8;
					end
					if (dec_op == OP_ADD16 || dec_op == OP_ADC16 || dec_op == OP_SUBB16 ||
						dec_op == OP_INC16 || dec_op == OP_DEC16) begin
						unique case (wr_slot)
							2'h0: next_bc = alu_bus.res16;
							2'h1: next_de = alu_bus.res16;
							2'h2: begin
								// RL14 prefixed destination is the index register
								if (!is_pfx) begin
									next_pointer_pair = alu_bus.res16;
								end else if (idx_sel) begin
									next_index_reg_second = alu_bus.res16;
								end else begin
									next_index_reg_first = alu_bus.res16;
								end
							end
							2'h3: next_stack_pointer = alu_bus.res16;
						endcase
					end
				end
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state    <= ST_IDLE;
			acc      <= RST_BYTE;
			flags    <= RST_BYTE;
			bc       <= RST_WORD;
			de       <= RST_WORD;
			pointer_pair     <= RST_WORD;
			stack_pointer    <= RST_WORD;
			index_reg_first  <= RST_WORD;
			index_reg_second <= RST_WORD;
			mem_data <= RST_BYTE;
			mem_addr <= RST_WORD;
			instr    <= RST_INSTR;
			done     <= 1'b0;
			illegal  <= 1'b0;
			tcnt     <= '0;
			last_t   <= '0;
		end else begin
			state    <= next_state;
			acc      <= next_acc;
			flags    <= next_flags;
			bc       <= next_bc;
			de       <= next_de;
			pointer_pair     <= next_pointer_pair;
			stack_pointer    <= next_stack_pointer;
			index_reg_first  <= next_index_reg_first;
			index_reg_second <= next_index_reg_second;
			mem_data <= next_mem_data;
			mem_addr <= next_mem_addr;
			instr    <= next_instr;
			done     <= next_done;
			illegal  <= next_illegal;
			tcnt     <= next_tcnt;
			last_t   <= next_last_t;
		end
	end

endmodule // mia_top

// file: verification/mia_top_checker.sv
// bus-side assertions for the datapath register slave
module mia_top_checker (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	input  wire logic        hreadyout,
	input  wire logic        hresp
);
	timeunit 1ns;
	timeprecision 1ns;
	import mia_pkg::*;
	logic       take;
	logic       rd;
	logic [7:0] a8;
	assign take = hsel && htrans[1] && hready && (hsize == SIZE_WORD);
	assign rd   = take && !hwrite;
	assign a8   = haddr[7:0];
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_resp_okay; hresp == 1'b0; endproperty
	property p_rd_wait; rd |=> !hreadyout ##1 hreadyout; endproperty
	property p_wr_nowait; take && hwrite |=> hreadyout; endproperty
	property p_wait_cause; !hreadyout |-> $past(rd); endproperty
	property p_rdata_hold; !$stable(hrdata) |-> $past(hreadyout) == 1'b0; endproperty
	property p_unmapped; rd && a8 >= 8'h30 |-> ##2 hrdata == 32'h0; endproperty
	property p_stat_fmt;
		rd && a8 == OFF_STATUS |-> ##2 (hrdata[31:13] == 19'h0 && hrdata[7:3] == 5'h0 && !(hrdata[0] && hrdata[1]));
	endproperty
	property p_tcount;
		rd && a8 == OFF_STATUS |-> ##2 hrdata[12:8] inside {5'h00, 5'h06, 5'h07, 5'h0a, 5'h0b, 5'h0f, 5'h13, 5'h17};
	endproperty
	property p_pair_fmt; rd && a8 >= OFF_BC && a8 <= OFF_INDEX_SECOND |-> ##2 hrdata[31:16] == 16'h0; endproperty
	a_resp_okay: assert property (p_resp_okay)
		else $error("slave response not okay");
	a_rd_wait: assert property (p_rd_wait)
		else $error("read did not wait exactly one cycle");
	a_wr_nowait: assert property (p_wr_nowait)
		else $error("write was stalled");
	a_wait_cause: assert property (p_wait_cause)
		else $error("wait state without a read");
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data changed outside a read");
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	a_stat_fmt: assert property (p_stat_fmt)
		else $error("status word malformed");
	a_tcount: assert property (p_tcount)
		else $error("T state count not a legal length");
	a_pair_fmt: assert property (p_pair_fmt)
		else $error("pair register upper bits set");
	c_rd: cover property (rd ##2 hreadyout);
	c_done: cover property (rd && a8 == OFF_STATUS ##2 hrdata[1]);
	c_unmapped: cover property (rd && a8 >= 8'h30);
endmodule // mia_top_checker

bind mia_top mia_top_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp));

// file: verification/mia_top_bench.sv
// self-checking bench for the memory and 16-bit arithmetic datapath
module mia_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import mia_pkg::*;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic        hwrite;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	int          miscompares;
	int          n_tests;
	int          cycles;
	logic [15:0] exp_add [4] = '{16'h0101, 16'h0102, 16'h0200, 16'h0104};

	mia_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

	always #5 hclk = ~hclk;

	task automatic complete_run();
		if (miscompares == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// a hang would otherwise never reach the verdict
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			complete_run();
		end
	end

	// one single transfer, held until hready is sampled high
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		bus(1'b1, a, d, rd);
	endtask

	task automatic chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		bus(1'b0, a, 32'h0, rd);
		cmp(rd, exp);
	endtask

	task automatic go(input logic [23:0] ins, output logic [31:0] rd);
		wr(OFF_INSTR, {8'h00, ins});
		wr(OFF_CTRL, 32'h1);
		do bus(1'b0, OFF_STATUS, 32'h0, rd);
		while (rd[STAT_DONE_BIT] !== 1'b1);
	endtask

	// status must show done and the exact T state count
	task automatic exe(input logic [23:0] ins, input logic [4:0] t);
		logic [31:0] rd;
		go(ins, rd);
		cmp(rd, {19'h0, t, 8'h02});
	endtask

	task automatic t_cmp();
		wr(OFF_PTR_PAIR, 32'h0040);
		wr(OFF_ACCF, 32'h1000);
		wr(OFF_MEMD, 32'h20);
		exe(24'h0000be, 5'h07);
		chk(OFF_ACCF, 32'h1083);
		chk(OFF_MEMD, 32'h20);
		wr(OFF_INDEX_FIRST, 32'h1000);
		wr(OFF_ACCF, 32'h8000);
		wr(OFF_MEMD, 32'h01);
		exe(24'hfebedd, 5'h13);
		chk(OFF_ACCF, 32'h8016);
		chk(OFF_MEMA, 32'h0ffe);
		wr(OFF_INDEX_SECOND, 32'h2000);
		exe(24'h05befd, 5'h13);
		chk(OFF_MEMA, 32'h2005);
	endtask

	task automatic t_incdec();
		wr(OFF_ACCF, 32'h0001);
		wr(OFF_MEMD, 32'h7f);
		exe(24'h000034, 5'h0b);
		chk(OFF_MEMD, 32'h80);
		chk(OFF_ACCF, 32'h0095);
		exe(24'h000035, 5'h0b);
		chk(OFF_MEMD, 32'h7f);
		chk(OFF_ACCF, 32'h0017);
		// overflow flag preset so that its clearing is visible
		wr(OFF_ACCF, 32'h0004);
		wr(OFF_MEMD, 32'h01);
		exe(24'h000035, 5'h0b);
		chk(OFF_ACCF, 32'h0042);
		wr(OFF_ACCF, 32'h0004);
		wr(OFF_MEMD, 32'hff);
		exe(24'h0134fd, 5'h17);
		chk(OFF_MEMD, 32'h00);
		chk(OFF_ACCF, 32'h0050);
		chk(OFF_MEMA, 32'h2001);
		exe(24'h8035dd, 5'h17);
		chk(OFF_ACCF, 32'h0092);
		chk(OFF_MEMA, 32'h0f80);
	endtask

	task automatic t_add16();
		wr(OFF_BC, 32'h0001);
		wr(OFF_DE, 32'h0002);
		wr(OFF_STACK_PTR, 32'h0004);
		for (int p = 0; p < 4; p++) begin
			wr(OFF_PTR_PAIR, 32'h0100);
			exe({16'h0, 2'b00, p[1:0], 4'h9}, 5'h0b);
			chk(OFF_PTR_PAIR, {16'h0, exp_add[p]});
		end
		wr(OFF_PTR_PAIR, 32'hffff);
		wr(OFF_ACCF, 32'h00c4);
		exe(24'h000009, 5'h0b);
		chk(OFF_ACCF, 32'h00d5);
		wr(OFF_INDEX_FIRST, 32'h0fff);
		exe(24'h0009dd, 5'h0f);
		chk(OFF_INDEX_FIRST, 32'h1000);
		chk(OFF_ACCF, 32'h00d4);
		wr(OFF_INDEX_SECOND, 32'h8000);
		exe(24'h0029fd, 5'h0f);
		chk(OFF_INDEX_SECOND, 32'h0000);
		chk(OFF_ACCF, 32'h00c5);
	endtask

	task automatic t_ext16();
		wr(OFF_PTR_PAIR, 32'h7fff);
		wr(OFF_DE, 32'h0000);
		wr(OFF_ACCF, 32'h0001);
		exe(24'h005aed, 5'h0f);
		chk(OFF_PTR_PAIR, 32'h8000);
		chk(OFF_ACCF, 32'h0094);
		wr(OFF_PTR_PAIR, 32'h0000);
		wr(OFF_BC, 32'h0000);
		wr(OFF_ACCF, 32'h0001);
		exe(24'h0042ed, 5'h0f);
		chk(OFF_PTR_PAIR, 32'hffff);
		chk(OFF_ACCF, 32'h0093);
		wr(OFF_PTR_PAIR, 32'h1000);
		wr(OFF_STACK_PTR, 32'h1000);
		wr(OFF_ACCF, 32'h0000);
		exe(24'h0072ed, 5'h0f);
		chk(OFF_PTR_PAIR, 32'h0000);
		chk(OFF_ACCF, 32'h0042);
	endtask

	task automatic t_pair();
		logic [31:0] rd;
		wr(OFF_ACCF, 32'h00ff);
		exe(24'h00000b, 5'h06);
		chk(OFF_BC, 32'hffff);
		exe(24'h000033, 5'h06);
		chk(OFF_STACK_PTR, 32'h1001);
		wr(OFF_INDEX_FIRST, 32'hffff);
		exe(24'h0023dd, 5'h0a);
		chk(OFF_INDEX_FIRST, 32'h0000);
		chk(OFF_ACCF, 32'h00ff);
		// a prefix after a prefix must not execute
		go(24'h00dddd, rd);
		cmp({29'h0, rd[2:0]}, 32'h6);
		chk(OFF_INDEX_FIRST, 32'h0000);
		chk(8'h30, 32'h0);
	endtask

	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = SIZE_WORD;
		hwdata = 32'h0;
		miscompares = 0;
		n_tests = 0;
		cycles = 0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_cmp();
		t_incdec();
		t_add16();
		t_ext16();
		t_pair();
		complete_run();
	end
endmodule // mia_top_bench
